// *** core/bridge_pkg.sv ***
// constants, field layouts and carrier types for the half-bridge serial control block
// assumes one system clock; serial pins arrive asynchronous to it
// How it works
// - global fault flags at bits 15,14,13,0
// - two-bit state per bridge, bits 12:1
// - over-current overrides a reported under-load
// - no path from over-current to under-load; code takes one when a fault clear meets underload_in in the same cycle
// - thermal flag on serial out before first edge
// - bridge control from command bits 12 to 1
// - disabled bridge output goes high impedance
// - never both switches of one bridge on
// - dead time on every side change
// - valid frame: 16 bits plus whole bytes
// - bad frame discarded, outputs keep state
// - short but valid chain frame is accepted
// - thermal pre-bit ORed with serial input
// - power-on reset clears drivers and registers
// - turn-on data accepted only above lockout
// - drivers hold until supply, command or fault
// - sample input on fall, shift out on rise
// - select rise loads last 16 bits; output tri-stated
// - bits 12:7 enables, 6:1 configs, bridges 6..1
// - command bit 15 clears latched faults
package bridge_pkg;
  localparam int NUM_BRIDGES = 6;
  localparam int FRAME_BITS = 16;
  localparam int CHAIN_BITS = 8;
  localparam int CNT_W = 8;
  localparam int BIT_OVERCURRENT = 15;
  localparam int BIT_SUPPLY_FAIL = 14;
  localparam int BIT_UNDERLOAD = 13;
  localparam int BIT_THERMAL_WARN = 0;
  localparam int BIT_FAULT_CLEAR = 15;
  localparam int ENABLE_LSB = 7;
  localparam int CONFIG_LSB = 1;
  localparam int STATE_LSB = 1;
  localparam logic [1:0] CODE_DISABLED = 2'h0;
  localparam logic [1:0] CODE_OVERCURRENT = 2'h1;
  localparam logic [1:0] CODE_UNDERLOAD = 2'h2;
  localparam logic [1:0] CODE_ENABLED = 2'h3;
  localparam logic [15:0] FRAME_RESET = 16'h0000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEADTIME_NS = 1000;
  localparam int DEADTIME_CYCLES = (DEADTIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEAD_W = 10;

  typedef struct packed {
    logic [NUM_BRIDGES-1:0] enable;
    logic [NUM_BRIDGES-1:0] config_hi;
    logic fault_clear;
  } command_s;

  typedef struct packed {
    logic [NUM_BRIDGES-1:0] overcurrent;
    logic [NUM_BRIDGES-1:0] underload;
    logic [NUM_BRIDGES-1:0] thermal_shutdown;
    logic supply_fail;
    logic thermal_warning;
  } fault_s;

  typedef enum logic [1:0] {SW_OFF, SW_DEAD, SW_HIGH, SW_LOW} switch_e;
endpackage

// *** core/half_bridge_spi_control_status.sv ***
// serial command and status port with bridge switch control
// assumes fault inputs are synchronous to mclk; serial pins are not
`timescale 1ns/1ps
`default_nettype none
module half_bridge_spi_control_status
  import bridge_pkg::*;
#(
  parameter int DEAD_CYCLES = DEADTIME_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // supply and fault monitors
  input wire logic logic_supply_ok,
  input wire logic supply_fail_in,
  input wire logic thermal_warning_in,
  input wire logic [NUM_BRIDGES-1:0] overcurrent_in,
  input wire logic [NUM_BRIDGES-1:0] underload_in,
  input wire logic [NUM_BRIDGES-1:0] thermal_shutdown_in,
  // bridge switches
  output logic [NUM_BRIDGES-1:0] high_side_switch,
  output logic [NUM_BRIDGES-1:0] low_side_switch,
  // accepted command frame and status view
  output logic [15:0] command_frame,
  output logic [15:0] diagnostic_status_frame
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam logic [2:0] PIN_IDLE = 3'h4; // select high, clock and data low
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      prev <= PIN_IDLE;
    end else begin
      sync1 <= {chip_select_n, sclk, sdi};
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  logic cs_s, sclk_s, sdi_s;
  assign cs_s = sync2[2];
  assign sclk_s = sync2[1];
  assign sdi_s = sync2[0];
  logic cs_fall, cs_rise, sclk_rise, sclk_fall, active;
  assign cs_fall = prev[2] & ~cs_s;
  assign cs_rise = ~prev[2] & cs_s;
  assign active = ~cs_s & ~prev[2];
  assign sclk_rise = active & ~prev[1] & sclk_s;
  assign sclk_fall = active & prev[1] & ~sclk_s;

  // ----------------------------------------
  // fault latches and bridge state codes
  // ----------------------------------------
  fault_s faults;
  logic clear_pulse;
  logic [1:0] code [NUM_BRIDGES];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      faults <= '0;
    end else begin
      faults.supply_fail <= supply_fail_in;
      faults.thermal_warning <= thermal_warning_in;
      // set wins over clear
      faults.overcurrent <= (clear_pulse ? '0 : faults.overcurrent) | overcurrent_in;
      faults.underload <= (clear_pulse ? '0 : faults.underload) | underload_in;
      faults.thermal_shutdown <= (clear_pulse ? '0 : faults.thermal_shutdown)
                                 | thermal_shutdown_in;
    end
  end

  command_s cmd;
  always_comb begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      if (faults.overcurrent[i]) begin
        code[i] = CODE_OVERCURRENT;
      end else if (faults.underload[i]) begin
        code[i] = CODE_UNDERLOAD;
      end else if (cmd.enable[i]) begin
        code[i] = CODE_ENABLED;
      end else begin
        code[i] = CODE_DISABLED;
      end
    end
  end

  logic [15:0] status_now;
  always_comb begin
    status_now = FRAME_RESET;
    status_now[BIT_OVERCURRENT] = |faults.overcurrent;
    status_now[BIT_SUPPLY_FAIL] = faults.supply_fail;
    status_now[BIT_UNDERLOAD] = |faults.underload;
    status_now[BIT_THERMAL_WARN] = faults.thermal_warning;
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      status_now[STATE_LSB + 2*i +: 2] = code[i];
    end
  end
  logic tsd_any;
  assign tsd_any = |faults.thermal_shutdown;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      diagnostic_status_frame <= FRAME_RESET;
    end else begin
      diagnostic_status_frame <= status_now;
    end
  end

  // ----------------------------------------
  // serial shifter and frame counter
  // ----------------------------------------
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [CNT_W-1:0] bit_count;
  logic pre_phase;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_shift <= FRAME_RESET;
      bit_count <= '0;
    end else if (cs_fall) begin
      bit_count <= '0;
    end else if (sclk_fall) begin
      rx_shift <= {rx_shift[14:0], sdi_s};
      if (bit_count == FRAME_BITS + CHAIN_BITS - 1) begin
        bit_count <= CNT_W'(FRAME_BITS); // wrap byte count in the chain section
      end else begin
        bit_count <= bit_count + 1'b1;
      end
    end
  end

  // snapshot at select fall, shift on rise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_shift <= FRAME_RESET;
      pre_phase <= 1'b0;
    end else if (cs_fall) begin
      tx_shift <= status_now;
      pre_phase <= 1'b1;
    end else if (sclk_rise) begin
      if (pre_phase) begin
        pre_phase <= 1'b0;
      end else begin
        tx_shift <= {tx_shift[14:0], rx_shift[0]};
      end
    end
  end

  // serial output: pre-bit muxed and ORed with input, tri-state when deselected
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~cs_s;
      if (pre_phase | cs_fall) begin
        sdo <= tsd_any | sdi_s;
      end else begin
        sdo <= tx_shift[15];
      end
    end
  end

  // ----------------------------------------
  // command register
  // ----------------------------------------
  logic frame_ok;
  assign frame_ok = (bit_count == CNT_W'(FRAME_BITS));

  // accepted frame waits here until the buffer takes it
  logic [15:0] accepted_frame;
  logic accept_valid;
  logic accept_ready;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accepted_frame <= FRAME_RESET;
      accept_valid <= 1'b0;
    end else if (cs_rise && frame_ok && logic_supply_ok) begin
      accepted_frame <= rx_shift;
      accept_valid <= 1'b1;
    end else if (accept_ready) begin
      accept_valid <= 1'b0;
    end
  end

  // two-entry buffer so a stalled command register loses no frame
  logic buf_valid;
  logic buf_ready;
  logic [15:0] buf_frame;
  frame_pair_buffer #(
    .WIDTH(FRAME_BITS)
  ) frame_pair_buffer_i (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(accept_valid),
    .in_ready(accept_ready),
    .in_data(accepted_frame),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_frame)
  );

  // a fault clear takes one cycle; the next frame waits for it
  assign buf_ready = ~clear_pulse;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      command_frame <= FRAME_RESET;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= 1'b0;
      if (buf_valid && buf_ready) begin
        command_frame <= buf_frame;
        clear_pulse <= buf_frame[BIT_FAULT_CLEAR];
      end
    end
  end
  assign cmd.enable = command_frame[ENABLE_LSB +: NUM_BRIDGES];
  assign cmd.config_hi = command_frame[CONFIG_LSB +: NUM_BRIDGES];
  assign cmd.fault_clear = command_frame[BIT_FAULT_CLEAR];

  // ----------------------------------------
  // bridge drivers with dead time
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_BRIDGES; g++) begin : gen_bridge
      switch_e st;
      switch_e target;
      logic [DEAD_W-1:0] dead;
      logic shut;
      assign shut = faults.overcurrent[g] | faults.thermal_shutdown[g]
                    | faults.supply_fail | ~logic_supply_ok;
      always_comb begin
        if (!cmd.enable[g] || shut) begin
          target = SW_OFF;
        end else if (cmd.config_hi[g]) begin
          target = SW_HIGH;
        end else begin
          target = SW_LOW;
        end
      end
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          st <= SW_OFF;
          dead <= '0;
        end else begin
          case (st)
            SW_OFF: begin
              if (target != SW_OFF) begin
                st <= SW_DEAD;
                dead <= DEAD_W'(DEAD_CYCLES);
              end
            end
            SW_DEAD: begin
              if (target == SW_OFF) begin
                st <= SW_OFF;
              end else if (dead <= DEAD_W'(1)) begin
                st <= target;
              end else begin
                dead <= dead - 1'b1;
              end
            end
            SW_HIGH, SW_LOW: begin
              if (target != st) begin
                st <= (target == SW_OFF) ? SW_OFF : SW_DEAD;
                dead <= DEAD_W'(DEAD_CYCLES);
              end
            end
            default: st <= SW_OFF;
          endcase
        end
      end
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          high_side_switch[g] <= 1'b0;
          low_side_switch[g] <= 1'b0;
        end else begin
          high_side_switch[g] <= (st == SW_HIGH) && (target == SW_HIGH);
          low_side_switch[g] <= (st == SW_LOW) && (target == SW_LOW);
        end
      end
    end
  endgenerate

endmodule

// two-entry frame buffer, valid and ready on both sides
module frame_pair_buffer
  import bridge_pkg::*;
#(
  parameter int WIDTH = FRAME_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------
  // storage, pointers and fill count
  // ----------------------------------------
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_FULL = 2'h2;
  logic [WIDTH-1:0] slot [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fill;
  logic push;
  logic pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign in_ready = (fill != FILL_FULL);
  assign out_valid = (fill != FILL_EMPTY);
  assign out_data = slot[rd_ptr];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot <= '{default: '0};
    end else if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill <= FILL_EMPTY;
    end else if (push && !pop) begin
      fill <= fill + 1'b1;
    end else if (pop && !push) begin
      fill <= fill - 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** sim/hb_chk.sv ***
// checker on the top ports of the half-bridge serial block
// assumes the design is built with DEAD_CYCLES of 4, as in the bench
`timescale 1ns/1ps
`default_nettype none
module hb_chk
  import bridge_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic sdo_oe,
  input wire logic logic_supply_ok,
  input wire logic supply_fail_in,
  input wire logic thermal_warning_in,
  input wire logic [NUM_BRIDGES-1:0] overcurrent_in,
  input wire logic [NUM_BRIDGES-1:0] high_side_switch,
  input wire logic [NUM_BRIDGES-1:0] low_side_switch,
  input wire logic [15:0] command_frame,
  input wire logic [15:0] diagnostic_status_frame
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_no_shoot_through: assert property ((high_side_switch & low_side_switch) == '0)
    else $error("both switches of a bridge on");
  a_disabled_bridge_off: assert property ($stable(command_frame) [*3] |->
    ((high_side_switch | low_side_switch) & ~command_frame[12:7]) == '0)
    else $error("disabled bridge still driven");
  a_config_side_match: assert property ($stable(command_frame) [*2] |->
    ((high_side_switch & ~command_frame[6:1]) | (low_side_switch & command_frame[6:1])) == '0)
    else $error("wrong side on for config");
  a_dead_high_low: assert property ($fell(high_side_switch[0]) |-> !low_side_switch[0] [*4])
    else $error("low side on inside dead time");
  a_dead_low_high: assert property ($fell(low_side_switch[0]) |-> !high_side_switch[0] [*4])
    else $error("high side on inside dead time");
  a_tristate_idle: assert property (chip_select_n [*6] |-> !sdo_oe)
    else $error("serial out driven while deselected");
  a_drive_selected: assert property (!chip_select_n [*6] |-> sdo_oe)
    else $error("serial out not driven while selected");
  a_flags_mirror: assert property (diagnostic_status_frame[14] == $past(supply_fail_in, 2) &&
    diagnostic_status_frame[0] == $past(thermal_warning_in, 2))
    else $error("supply or warning flag wrong");
  a_oc_code_shown: assert property (overcurrent_in[0] |-> ##[1:3]
    (diagnostic_status_frame[2:1] == CODE_OVERCURRENT && diagnostic_status_frame[15]))
    else $error("over-current not reported");
  a_supply_drivers_off: assert property ((!logic_supply_ok || supply_fail_in) [*3] |->
    (high_side_switch | low_side_switch) == '0)
    else $error("drivers on with bad supply");
  c_load: cover property ($changed(command_frame));
  c_oc: cover property (diagnostic_status_frame[2:1] == CODE_OVERCURRENT);
  c_sel: cover property ($rose(sdo_oe));
endmodule
bind half_bridge_spi_control_status hb_chk hb_chk_i (.*);
`default_nettype wire

// *** sim/hb_host.sv ***
// host master model for the serial link
// assumes the device samples on sclk fall and shifts out on sclk rise
`timescale 1ns/1ps
`default_nettype none
module hb_host (
  // serial link
  output var logic chip_select_n,
  output var logic sclk,
  output var logic sdi,
  input wire logic sdo
);
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q,
                      output logic pre);
    q = '0;
    sclk = 1'b0;
    sdi = 1'b0;
    #40 chip_select_n = 1'b0;
    #60 pre = sdo;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = d[i];
      #40 q[i] = sdo;
      sclk = 1'b0;
      #40;
    end
    sdi = 1'b0;
    chip_select_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// *** sim/half_bridge_spi_control_status_test.sv ***
// self-checking bench for the half-bridge serial block
// assumes hb_host and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module half_bridge_spi_control_status_test;
  import bridge_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, supply_ok = 1'b1, sfail = 1'b0, twarn = 1'b0;
  logic [5:0] oc = '0, ul = '0, tsd = '0, hs, ls;
  logic cs_n, sclk, sdi, sdo, sdo_oe, pre;
  logic [15:0] cmd, stat, prev = '0;
  logic [31:0] q;
  logic [15:0] expq[$];
  int failures = 0, total_checks = 0;
  int bad_len[4] = '{15, 17, 20, 8};
  always #2.5 mclk = ~mclk;
  half_bridge_spi_control_status #(.DEAD_CYCLES(4)) half_bridge_spi_control_status_i (
    .mclk(mclk), .rst_n(rst_n), .chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .logic_supply_ok(supply_ok), .supply_fail_in(sfail),
    .thermal_warning_in(twarn), .overcurrent_in(oc), .underload_in(ul),
    .thermal_shutdown_in(tsd), .high_side_switch(hs), .low_side_switch(ls),
    .command_frame(cmd), .diagnostic_status_frame(stat));
  hb_host hb_host_i (.chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_oe ? sdo : 1'bz));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (rst_n && cmd !== prev) begin
      if (expq.size() == 0) chk(cmd, prev);
      else chk(cmd, expq.pop_front());
      prev = cmd;
    end
  end
  task automatic send(input int n, input logic [31:0] d, input bit ok);
    if (ok) expq.push_back(d[15:0]);
    hb_host_i.xfer(n, d, q, pre);
    for (int i = 0; i < 50 && expq.size() > 0; i++) @(negedge mclk);
    if (expq.size() > 0) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic chk_sw(input logic [5:0] en, input logic [5:0] cf);
    repeat (12) @(negedge mclk);
    chk({hs, ls}, {en & cf, en & ~cf});
  endtask
  task automatic pulse(input logic [5:0] o, input logic [5:0] u, input logic [5:0] t);
    @(negedge mclk);
    oc = o;
    ul = u;
    tsd = t;
    @(negedge mclk);
    {oc, ul, tsd} = '0;
    repeat (3) @(negedge mclk);
  endtask
  function automatic logic [15:0] exp_stat(input logic [5:0] en, o, u);
    logic [15:0] s;
    s = {|o, sfail, |u, 12'h000, twarn};
    for (int b = 0; b < 6; b++)
      s[2*b+1 +: 2] = o[b] ? CODE_OVERCURRENT : u[b] ? CODE_UNDERLOAD :
                      en[b] ? CODE_ENABLED : CODE_DISABLED;
    return s;
  endfunction
  initial begin
    logic [5:0] en, cf;
    logic [31:0] d;
    logic [15:0] e;
    void'($urandom(31708));
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk({cmd, hs, ls}, '0);
    send(16, 32'h1f80, 1);
    chk_sw(6'h3f, 6'h00);
    send(16, 32'h1ffe, 1);
    chk_sw(6'h3f, 6'h3f);
    repeat (3) begin
      en = 6'($urandom);
      cf = 6'($urandom);
      send(16, {19'h0, en, cf, ~cmd[0]}, 1);
      chk_sw(en, cf);
    end
    foreach (bad_len[k]) send(bad_len[k], $urandom, 0);
    chk_sw(en, cf);
    d = $urandom;
    d[15:0] = {3'h0, en, cf, ~cmd[0]};
    send(24, d, 1);
    d = $urandom;
    d[15:0] = {3'h0, en, cf, ~cmd[0]};
    send(32, d, 1);
    chk(q[15:0], d[31:16]);
    twarn = 1'($urandom);
    pulse(6'h00, 6'h01, 6'h00);
    pulse(6'h03, 6'h00, 6'h04);
    pulse(6'h00, 6'h02, 6'h00);
    e = exp_stat(cmd[12:7], 6'h03, 6'h03);
    chk(stat, e);
    send(16, {16'h0, 1'b1, 2'h0, en, cf, 1'b0}, 1);
    chk(q[15:0], e);
    chk(pre, 1'b1);
    repeat (3) @(negedge mclk);
    chk(stat, exp_stat(en, 6'h00, 6'h00));
    supply_ok = 1'b0;
    send(16, {19'h0, ~en, cf, 1'b1}, 0);
    chk({hs, ls}, '0);
    supply_ok = 1'b1;
    sfail = 1'b1;
    repeat (6) @(negedge mclk);
    chk({hs, ls, stat[14]}, 13'h0001);
    sfail = 1'b0;
    chk_sw(en, cf);
    stop_test();
  end
endmodule
`default_nettype wire
